// File: src/passthru_consts.svh
`ifndef PASSTHRU_CONSTS_SVH
`define PASSTHRU_CONSTS_SVH

// ****************************************
// Add-On register offsets.
// ****************************************
`define PT_DATA_OFFSET 7'h2C

// ****************************************
// Pass-thru region windows.
// ****************************************
`define PT_REGION0_BASE 32'h1000_0000
`define PT_REGION1_BASE 32'h2000_0000
`define PT_REGION2_BASE 32'h3000_0000
`define PT_REGION3_BASE 32'h4000_0000
`define PT_REGION_MASK 32'hFFFF_0000

// ****************************************
// Reset values and timing counts.
// ****************************************
`define PT_DATA_RESET 32'h0000_0000
`define PT_RETRY_FIRST 4'hF
`define PT_RETRY_NEXT 4'h8
`define PT_HOLDOFF_CYCLES 2'h2

`endif

// File: src/passthru_pkg.sv
package passthru_pkg;

  typedef enum logic [1:0] {
    PT_IDLE,
    PT_ACTIVE,
    PT_HOLDOFF
  } pt_state_type;

  typedef logic [1:0] region_type;
  typedef logic [31:0] word_type;

endpackage

// File: src/passthru_region_match.sv
`timescale 1ns/1ns
`default_nettype none

module passthru_region_match #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'hFFFF_0000
) (
  input wire logic [31:0] addr,
  output logic hit
);

  // ****************************************
  // Compares the masked address with the window base.
  // ****************************************
  assign hit = ((addr & MASK) == (BASE & MASK));

endmodule

`default_nettype wire

// File: src/passthru_burst_read_addon_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "passthru_consts.svh"

module passthru_burst_read_addon_port (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic pci_addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic [3:0] pci_be_n,
  input wire logic pci_read,
  input wire logic pci_frame,
  input wire logic pci_irdy,
  output logic pci_accept,
  output logic pci_trdy,
  output logic pci_stop,
  output passthru_pkg::word_type pci_rdata,
  input wire logic addon_select_n,
  input wire logic [6:2] addon_addr,
  input wire logic [3:0] addon_byte_enable_n,
  input wire logic addon_write_strobe_n,
  input wire logic addon_read_strobe_n,
  input wire logic [31:0] addon_data_in,
  output passthru_pkg::word_type addon_data_out,
  output logic addon_data_oe,
  input wire logic passthru_addr_out_n,
  input wire logic passthru_ready_n,
  output logic passthru_attention_n,
  output logic passthru_burst_n,
  output passthru_pkg::region_type passthru_region_number,
  output logic passthru_write_dir,
  output logic [3:0] passthru_byte_enable_n
);
  import passthru_pkg::*;

  localparam logic [31:0] REGION_BASE [4] = '{
    `PT_REGION0_BASE, `PT_REGION1_BASE, `PT_REGION2_BASE, `PT_REGION3_BASE
  };

  pt_state_type state_q;
  word_type address_reg_q;
  word_type data_reg_q;
  word_type data_d;
  logic [3:0] region_hit;
  logic any_hit;
  region_type hit_region;
  logic [3:0] timer_q;
  logic [3:0] timer_limit;
  logic first_q;
  logic retry_q;
  logic [1:0] holdoff_q;
  logic attention_n_q;
  logic burst_n_q;
  region_type region_q;
  logic [3:0] be_n_q;
  logic trdy_q;
  logic stop_q;
  word_type rdata_q;
  word_type data_out_q;
  logic data_oe_q;
  logic start;
  logic data_sel;
  logic data_wr;
  logic phase_done;
  logic final_phase;
  logic retry_fire;

  // ****************************************
  // Region decode.
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_region
      passthru_region_match #(
        .BASE(REGION_BASE[gi]),
        .MASK(`PT_REGION_MASK)
      ) u_match (
        .addr(pci_addr),
        .hit(region_hit[gi])
      );
    end
  endgenerate

  always_comb begin
    hit_region = 2'h0;
    if (region_hit[0]) begin
      hit_region = 2'h0;
    end else if (region_hit[1]) begin
      hit_region = 2'h1;
    end else if (region_hit[2]) begin
      hit_region = 2'h2;
    end else if (region_hit[3]) begin
      hit_region = 2'h3;
    end
  end

  assign any_hit = |region_hit;
  assign start = (state_q == PT_IDLE) && pci_addr_valid && pci_read && any_hit;

  // ****************************************
  // Add-On register access.
  // ****************************************
  assign data_sel = !addon_select_n && ({addon_addr, 2'h0} == `PT_DATA_OFFSET);
  assign data_wr = data_sel && !addon_write_strobe_n;

  always_comb begin
    data_d = data_reg_q;
    for (int b = 0; b < 4; b++) begin
      if (data_wr && !addon_byte_enable_n[b]) begin
        data_d[8*b +: 8] = addon_data_in[8*b +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_reg_q <= `PT_DATA_RESET;
    end else if (clk_en) begin
      data_reg_q <= data_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_out_q <= 32'h0000_0000;
      data_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (!passthru_addr_out_n) begin
        data_out_q <= address_reg_q;
        data_oe_q <= 1'b1;
      end else if (data_sel && !addon_read_strobe_n) begin
        data_out_q <= data_reg_q;
        data_oe_q <= 1'b1;
      end else begin
        data_out_q <= 32'h0000_0000;
        data_oe_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Data phase pacing.
  // ****************************************
  assign phase_done = (state_q == PT_ACTIVE) && !attention_n_q && !passthru_ready_n;
  assign final_phase = phase_done && (!pci_frame || retry_q);
  assign timer_limit = first_q ? `PT_RETRY_FIRST : `PT_RETRY_NEXT;
  assign retry_fire = (state_q == PT_ACTIVE) && !phase_done && !retry_q &&
                      (timer_q == timer_limit - 4'h1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= PT_IDLE;
      holdoff_q <= 2'h0;
    end else if (clk_en) begin
      case (state_q)
        PT_IDLE: begin
          if (start) begin
            state_q <= PT_ACTIVE;
          end
        end
        PT_ACTIVE: begin
          if (final_phase) begin
            state_q <= PT_HOLDOFF;
            holdoff_q <= `PT_HOLDOFF_CYCLES - 2'h1;
          end
        end
        PT_HOLDOFF: begin
          if (holdoff_q == 2'h0) begin
            state_q <= PT_IDLE;
          end else begin
            holdoff_q <= holdoff_q - 2'h1;
          end
        end
        default: begin
          state_q <= PT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      address_reg_q <= 32'h0000_0000;
      region_q <= 2'h0;
      be_n_q <= 4'hF;
    end else if (clk_en && start) begin
      address_reg_q <= pci_addr;
      region_q <= hit_region;
      be_n_q <= pci_be_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      attention_n_q <= 1'b1;
      burst_n_q <= 1'b1;
    end else if (clk_en) begin
      if (start) begin
        attention_n_q <= 1'b0;
        burst_n_q <= 1'b1;
      end else if (state_q != PT_ACTIVE || final_phase) begin
        attention_n_q <= 1'b1;
        burst_n_q <= 1'b1;
      end else begin
        attention_n_q <= !pci_irdy;
        burst_n_q <= retry_q || retry_fire || !pci_frame;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_q <= 4'h0;
      first_q <= 1'b1;
      retry_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (clk_en) begin
      stop_q <= retry_fire;
      if (start) begin
        timer_q <= 4'h0;
        first_q <= 1'b1;
        retry_q <= 1'b0;
      end else if (phase_done) begin
        timer_q <= 4'h0;
        first_q <= 1'b0;
      end else if (state_q == PT_ACTIVE) begin
        timer_q <= retry_q ? timer_q : timer_q + 4'h1;
        retry_q <= retry_q || retry_fire;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trdy_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      trdy_q <= phase_done;
      if (phase_done) begin
        rdata_q <= data_d;
      end
    end
  end

  // ****************************************
  // Output drive.
  // ****************************************
  assign pci_accept = (state_q == PT_IDLE);
  assign pci_trdy = trdy_q;
  assign pci_stop = stop_q;
  assign pci_rdata = rdata_q;
  assign addon_data_out = data_out_q;
  assign addon_data_oe = data_oe_q;
  assign passthru_attention_n = attention_n_q;
  assign passthru_burst_n = burst_n_q;
  assign passthru_region_number = region_q;
  assign passthru_write_dir = 1'b0;
  assign passthru_byte_enable_n = be_n_q;

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_addr_capture;
    start && clk_en |=> address_reg_q == $past(pci_addr);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address not latched");

  property p_attention_on_hit;
    start && clk_en |=> !passthru_attention_n && passthru_burst_n;
  endproperty
  a_attention_on_hit: assert property (p_attention_on_hit) else $error("no attention on hit");

  property p_region;
    start && clk_en |=> passthru_region_number == $past(hit_region);
  endproperty
  a_region: assert property (p_region) else $error("wrong region number");

  property p_byte_enables;
    start && clk_en |=> passthru_byte_enable_n == $past(pci_be_n);
  endproperty
  a_byte_enables: assert property (p_byte_enables) else $error("byte enables wrong");

  property p_addr_out;
    !passthru_addr_out_n && clk_en |=> addon_data_oe && addon_data_out == $past(address_reg_q);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address not driven");

  property p_store;
    data_wr && addon_byte_enable_n == 4'h0 && clk_en |=> data_reg_q == $past(addon_data_in);
  endproperty
  a_store: assert property (p_store) else $error("data not stored");

  property p_phase;
    phase_done && clk_en |=> pci_trdy && pci_rdata == $past(data_d);
  endproperty
  a_phase: assert property (p_phase) else $error("phase not completed");

  property p_wait;
    state_q == PT_ACTIVE && !pci_irdy && clk_en |=> passthru_attention_n;
  endproperty
  a_wait: assert property (p_wait) else $error("attention kept in wait");

  property p_final;
    final_phase && clk_en |=> passthru_attention_n && passthru_burst_n ##1 !pci_trdy;
  endproperty
  a_final: assert property (p_final) else $error("final phase not closed");

  property p_holdoff;
    final_phase && clk_en |=> !pci_accept;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("accepted during holdoff");

  property p_retry;
    retry_fire && clk_en |=> pci_stop && passthru_burst_n && !passthru_attention_n;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not signalled");

  property p_idle;
    state_q == PT_IDLE |-> passthru_attention_n && passthru_burst_n;
  endproperty
  a_idle: assert property (p_idle) else $error("status active while idle");

  c_final: cover property (final_phase && clk_en);
  c_retry: cover property (retry_fire && clk_en);
  c_wait: cover property (state_q == PT_ACTIVE && !pci_irdy ##1 pci_irdy);

endmodule

`default_nettype wire

// File: verif/addon_logic_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "passthru_consts.svh"

module addon_logic_model #(
  parameter logic [31:0] DATA_BASE = 32'h5A00_0000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic en,
  input wire logic pace,
  input wire logic drop,
  input wire logic mute,
  input wire logic passthru_attention_n,
  output logic addon_select_n,
  output logic [6:2] addon_addr,
  output logic [3:0] addon_byte_enable_n,
  output logic addon_write_strobe_n,
  output logic addon_read_strobe_n,
  output logic [31:0] addon_data_in,
  output logic passthru_addr_out_n,
  output logic passthru_ready_n
);
  // ****************
  // Add-On writer that paces its words with ready.
  // ****************
  localparam logic [6:0] DATA_OFS = `PT_DATA_OFFSET;
  logic [31:0] idx = 32'h0;
  logic tick = 1'h0;
  logic seen = 1'h0;
  logic done;
  logic want;

  initial begin
    addon_select_n = 1'h1;
    addon_addr = 5'h00;
    addon_byte_enable_n = 4'hF;
    addon_write_strobe_n = 1'h1;
    addon_read_strobe_n = 1'h1;
    addon_data_in = 32'h0;
    passthru_addr_out_n = 1'h1;
    passthru_ready_n = 1'h1;
  end

  always @(posedge core_clk) begin
    done = !passthru_ready_n && !passthru_attention_n;
    #1;
    if (done) begin
      idx = idx + 32'h1;
    end
    tick = !tick;
    want = en && !srst && !mute && (!pace || tick);
    want = want && !passthru_attention_n;
    passthru_addr_out_n = !(en && !seen && !passthru_attention_n);
    seen = en && (seen || !passthru_attention_n);
    passthru_ready_n = !want;
    addon_select_n = !en;
    addon_addr = en ? DATA_OFS[6:2] : ~addon_addr;
    addon_byte_enable_n = en ? 4'h0 : ~addon_byte_enable_n;
    addon_write_strobe_n = !(en && (want || !drop));
    addon_data_in = en ? DATA_BASE + idx : ~addon_data_in;
  end
endmodule
`default_nettype wire

// File: verif/passthru_burst_read_addon_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "passthru_consts.svh"

module passthru_burst_read_addon_port_tb;
  import passthru_pkg::*;
  localparam logic [31:0] DATA_BASE = 32'h5A00_0000;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic clk_en = 1'h1;
  logic pci_read = 1'h1;
  logic pci_addr_valid = 1'h0;
  logic [31:0] pci_addr = 32'h0;
  logic [3:0] pci_be_n = 4'hF;
  logic pci_irdy = 1'h1;
  logic pci_frame, pci_accept, pci_trdy, pci_stop, addon_data_oe, tk, ir;
  logic en = 1'h0, pace = 1'h0, drop = 1'h0, mute = 1'h0, gap = 1'h0, act = 1'h0, rt = 1'h0;
  word_type pci_rdata, addon_data_out;
  logic addon_select_n, addon_write_strobe_n, addon_read_strobe_n;
  logic [6:2] addon_addr;
  logic [3:0] addon_byte_enable_n, passthru_byte_enable_n;
  logic [31:0] addon_data_in;
  logic passthru_addr_out_n, passthru_ready_n, passthru_attention_n, passthru_burst_n;
  logic passthru_write_dir;
  region_type passthru_region_number;
  int taken = 0, got = 0, nph = 1, cnt = 0, expd = 0, n, failures = 0, checks = 0;
  logic [31:0] bases [4] = '{`PT_REGION0_BASE, `PT_REGION1_BASE, `PT_REGION2_BASE,
                             `PT_REGION3_BASE};

  passthru_burst_read_addon_port DUT (.*);
  addon_logic_model #(.DATA_BASE(DATA_BASE)) partner (.*);

  always #25 core_clk = ~core_clk;
  always_comb pci_frame = taken < nph - 1;

  // ****************
  // Shared tasks.
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic start_chk(input logic [31:0] a, input logic [3:0] be, input region_type r,
                           input int k);
    pci_addr = a;
    pci_be_n = be;
    pci_addr_valid = 1'h1;
    nph = k;
    taken = 0;
    rt = 1'h0;
    act = 1'h1;
    en = 1'h1;
    @(posedge core_clk);
    #1;
    pci_addr_valid = 1'h0;
    @(negedge core_clk);
    chk("attention", 0, passthru_attention_n);
    chk("first burst", 1, passthru_burst_n);
    chk("region", r, passthru_region_number);
    chk("direction", 0, passthru_write_dir);
    chk("byte enables", be, passthru_byte_enable_n);
    @(negedge core_clk);
    chk("burst", k < 2, passthru_burst_n);
    chk("address out", a, addon_data_out);
  endtask

  task automatic wait_stop(output int c);
    c = 0;
    while (pci_stop !== 1'h1 && c < 40) begin
      @(negedge core_clk);
      c++;
    end
  endtask

  task automatic finish(input int e);
    for (int i = 0; i < 300 && act; i++) begin
      @(negedge core_clk);
    end
    chk("access end", 0, act);
    chk("holdoff one", 0, pci_accept);
    @(negedge core_clk);
    chk("holdoff two", 0, pci_accept);
    @(negedge core_clk);
    chk("accept again", 1, pci_accept);
    chk("phase count", e, got);
    en = 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // ****************
  // Monitor of phases and wait states.
  // ****************
  always @(posedge core_clk) begin
    tk = !passthru_ready_n && !passthru_attention_n;
    ir = pci_irdy;
    #1;
    cnt++;
    if (cnt > 2000) begin
      failures++;
      print_verdict();
    end
    if (tk) taken++;
    if (pci_stop === 1'h1) rt = 1'h1;
    if (pci_trdy === 1'h1) begin
      chk("read data", DATA_BASE + got, pci_rdata);
      got++;
    end
    if (act && !ir) chk("wait attention", 1, passthru_attention_n);
    if (act && tk && (taken == nph || rt)) begin
      act = 1'h0;
      chk("end attention", 1, passthru_attention_n);
      chk("end burst", 1, passthru_burst_n);
    end
    pci_irdy = !(gap && act && taken > 0 && cnt % 4 == 1);
  end

  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    srst = 1'h0;
    pci_addr = 32'h5000_0000;
    pci_addr_valid = 1'h1;
    @(posedge core_clk);
    #1;
    pci_addr_valid = 1'h0;
    repeat (2) @(negedge core_clk);
    chk("idle attention", 1, passthru_attention_n);
    chk("idle burst", 1, passthru_burst_n);
    chk("idle accept", 1, pci_accept);
    @(posedge core_clk);
    #1;
    for (int r = 0; r < 4; r++) begin
      pace = r[0];
      gap = r[0];
      drop = r[1];
      expd = expd + 2 * r + 1;
      start_chk(bases[r] + 32'h40 * r, 4'(3 * r), 2'(r), 2 * r + 1);
      finish(expd);
    end
    gap = 1'h0;
    mute = 1'h1;
    expd = expd + 1;
    start_chk(`PT_REGION2_BASE, 4'h0, 2'h2, 3);
    wait_stop(n);
    chk("first retry span", 1, n >= 14 && n <= 16);
    @(negedge core_clk);
    chk("retry burst", 1, passthru_burst_n);
    chk("retry attention", 0, passthru_attention_n);
    mute = 1'h0;
    finish(expd);
    pace = 1'h0;
    drop = 1'h0;
    expd = expd + 3;
    start_chk(`PT_REGION3_BASE + 32'h8, 4'h0, 2'h3, 4);
    for (int i = 0; i < 40 && taken < 1; i++) begin
      @(negedge core_clk);
    end
    mute = 1'h1;
    wait_stop(n);
    chk("next retry span", 1, n >= 8 && n <= 10);
    @(negedge core_clk);
    mute = 1'h0;
    finish(expd);
    print_verdict();
  end
endmodule
`default_nettype wire
